// ==== dpdc_pkg.sv ====
package dpdc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] MAIN_CFG_IDX   = 8'h6B;
    localparam logic [7:0] AUX_CFG_IDX    = 8'h6A;
    localparam logic [7:0] STATUS_IDX     = 8'h6E;
    localparam logic [7:0] MAIN_CFG_RST   = 8'h13;
    localparam logic [7:0] AUX_CFG_RST    = 8'h13;
    localparam logic [7:0] CFG_WR_MASK    = 8'h77;
    localparam int         DAMP_LSB       = 0;
    localparam int         GAIN_LSB       = 4;
    // bandwidth selection codes
    localparam logic [2:0] BW_4HZ         = 3'h0;
    localparam logic [2:0] BW_8HZ         = 3'h1;
    localparam logic [2:0] BW_18HZ        = 3'h2;
    localparam logic [2:0] BW_35HZ        = 3'h3;
    localparam logic [2:0] BW_70HZ        = 3'h4;
    // damping factor codes
    localparam logic [2:0] DF_1P2         = 3'h0;
    localparam logic [2:0] DF_2P5         = 3'h1;
    localparam logic [2:0] DF_5           = 3'h2;
    localparam logic [2:0] DF_10          = 3'h3;
    localparam logic [2:0] DF_20          = 3'h4;
    // damping select codes
    localparam logic [2:0] DS_001         = 3'h1;
    localparam logic [2:0] DS_010         = 3'h2;
    localparam logic [2:0] DS_011         = 3'h3;
    localparam logic [2:0] DS_100         = 3'h4;
    localparam logic [2:0] DS_101         = 3'h5;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;
endpackage

// ==== dpdc_damp_if.sv ====
`timescale 1ns/1ps
interface dpdc_damp_if;
    logic [2:0] damping_select;
    logic [2:0] bandwidth;
    logic [2:0] factor;
    logic       code_unused;
    modport decoder (input damping_select, input bandwidth, output factor, output code_unused);
    modport user    (output damping_select, output bandwidth, input factor, input code_unused);
endinterface

// ==== dpdc_damp_decode.sv ====
`timescale 1ns/1ps
module dpdc_damp_decode (
    dpdc_damp_if.decoder dmp
);
    logic wide_bw;
    logic top_bw;

    // bandwidth codes above 70 Hz are treated as 70 Hz
    assign wide_bw = (dmp.bandwidth >= dpdc_pkg::BW_35HZ);
    assign top_bw  = (dmp.bandwidth >= dpdc_pkg::BW_70HZ);

    always_comb begin
        dmp.code_unused = 1'b0;
        dmp.factor      = dpdc_pkg::DF_5;
        unique case (dmp.damping_select)
            dpdc_pkg::DS_001: begin
                if (dmp.bandwidth == dpdc_pkg::BW_4HZ) begin
                    dmp.factor = dpdc_pkg::DF_5;
                end else if (dmp.bandwidth == dpdc_pkg::BW_8HZ) begin
                    dmp.factor = dpdc_pkg::DF_2P5;
                end else begin
                    dmp.factor = dpdc_pkg::DF_1P2;
                end
            end
            dpdc_pkg::DS_010: begin
                dmp.factor = (dmp.bandwidth <= dpdc_pkg::BW_8HZ) ? dpdc_pkg::DF_5 : dpdc_pkg::DF_2P5;
            end
            dpdc_pkg::DS_011: begin
                dmp.factor = dpdc_pkg::DF_5;
            end
            dpdc_pkg::DS_100: begin
                dmp.factor = wide_bw ? dpdc_pkg::DF_10 : dpdc_pkg::DF_5;
            end
            dpdc_pkg::DS_101: begin
                dmp.factor = top_bw ? dpdc_pkg::DF_20 : (wide_bw ? dpdc_pkg::DF_10 : dpdc_pkg::DF_5);
            end
            default: begin
                // unused encodings keep the loop at factor 5 and raise a flag
                dmp.code_unused = 1'b1;
                dmp.factor      = dpdc_pkg::DF_5;
            end
        endcase
    end
endmodule

// ==== dpdc_config.sv ====
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
module dpdc_config #(
    parameter int ADDR_W = 12
) (
    input  wire logic              i_clk_sys,
    input  wire logic              i_sys_rst,
    input  wire logic              i_clk_en,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
    input  wire logic [2:0]        i_s_axi_awprot,
    input  wire logic              i_s_axi_awvalid,
    output logic                   o_s_axi_awready,
    input  wire logic [31:0]       i_s_axi_wdata,
    input  wire logic [3:0]        i_s_axi_wstrb,
    input  wire logic              i_s_axi_wvalid,
    output logic                   o_s_axi_wready,
    output logic [1:0]             o_s_axi_bresp,
    output logic                   o_s_axi_bvalid,
    input  wire logic              i_s_axi_bready,
    input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
    input  wire logic [2:0]        i_s_axi_arprot,
    input  wire logic              i_s_axi_arvalid,
    output logic                   o_s_axi_arready,
    output logic [31:0]            o_s_axi_rdata,
    output logic [1:0]             o_s_axi_rresp,
    output logic                   o_s_axi_rvalid,
    input  wire logic              i_s_axi_rready,
    // loop context from the dpll, same clock
    input  wire logic [2:0]        i_main_bandwidth,
    input  wire logic [2:0]        i_aux_bandwidth,
    input  wire logic              i_auto_detector_gain_enable,
    input  wire logic              i_main_low_rate_analog,
    // configuration towards the loops
    output logic [2:0]             o_main_damping_select,
    output logic [2:0]             o_main_damping_factor,
    output logic                   o_main_code_unused,
    output logic [2:0]             o_aux_damping_select,
    output logic [2:0]             o_aux_damping_factor,
    output logic                   o_aux_code_unused,
    output logic [2:0]             o_low_rate_analog_detector_gain,
    output logic                   o_detector_gain_apply
);
    localparam int IDX_W = ADDR_W - 2;

    generate
        if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
            $error("dpdc_config: ADDR_W must lie between 10 and 32");
        end
    endgenerate

    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_MAIN,
        SEL_AUX,
        SEL_STATUS
    } dpdc_sel_t;

    // all state in one word, filled by the comb process and registered once
    typedef struct packed {
        logic             aw_full;
        logic [IDX_W-1:0] aw_idx;
        logic             w_full;
        logic [7:0]       w_data;
        logic             w_lane0;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [7:0]       rdata;
        logic [1:0]       rresp;
        logic [7:0]       main_cfg;
        logic [7:0]       aux_cfg;
        logic [2:0]       main_factor;
        logic             main_unused;
        logic [2:0]       aux_factor;
        logic             aux_unused;
        logic [2:0]       det_gain;
        logic             det_apply;
    } dpdc_state_t;

    dpdc_state_t st;
    dpdc_state_t next_st;

    // state after reset: both loops at code 011, factor 5
    localparam dpdc_state_t RST_ST = '{
        main_cfg:    dpdc_pkg::MAIN_CFG_RST,
        aux_cfg:     dpdc_pkg::AUX_CFG_RST,
        main_factor: dpdc_pkg::DF_5,
        aux_factor:  dpdc_pkg::DF_5,
        det_gain:    dpdc_pkg::MAIN_CFG_RST[dpdc_pkg::GAIN_LSB +: 3],
        default:     '0
    };

    dpdc_damp_if main_dmp ();
    dpdc_damp_if aux_dmp ();

    // register index decode shared by the write and read paths
    function automatic dpdc_sel_t decode_idx(input logic [IDX_W-1:0] idx);
        if (idx == IDX_W'(dpdc_pkg::MAIN_CFG_IDX)) begin
            decode_idx = SEL_MAIN;
        end else if (idx == IDX_W'(dpdc_pkg::AUX_CFG_IDX)) begin
            decode_idx = SEL_AUX;
        end else if (idx == IDX_W'(dpdc_pkg::STATUS_IDX)) begin
            decode_idx = SEL_STATUS;
        end else begin
            decode_idx = SEL_NONE;
        end
    endfunction

    // only byte lane 0 carries the register; reserved bits always clear
    function automatic logic [7:0] cfg_merge(input logic [7:0] cur, input logic [7:0] data, input logic lane0);
        if (lane0) begin
            cfg_merge = data & dpdc_pkg::CFG_WR_MASK;
        end else begin
            cfg_merge = cur;
        end
    endfunction

    assign main_dmp.damping_select = st.main_cfg[dpdc_pkg::DAMP_LSB +: 3];
    assign main_dmp.bandwidth      = i_main_bandwidth;
    assign aux_dmp.damping_select  = st.aux_cfg[dpdc_pkg::DAMP_LSB +: 3];
    assign aux_dmp.bandwidth       = i_aux_bandwidth;

    dpdc_damp_decode u_main_decode (
        .dmp (main_dmp.decoder)
    );

    dpdc_damp_decode u_aux_decode (
        .dmp (aux_dmp.decoder)
    );

    // one item moves on each channel when valid and ready meet
    logic aw_take;
    logic w_take;
    logic ar_take;

    // readys fall with the enable so nothing is taken while state is frozen
    // a pending response blocks both halves: one write in flight at most
    assign o_s_axi_awready = i_clk_en & ~st.aw_full & ~st.bvalid;
    assign o_s_axi_wready  = i_clk_en & ~st.w_full & ~st.bvalid;
    assign o_s_axi_arready = i_clk_en & ~st.rvalid;
    assign aw_take         = o_s_axi_awready & i_s_axi_awvalid;
    assign w_take          = o_s_axi_wready & i_s_axi_wvalid;
    assign ar_take         = o_s_axi_arready & i_s_axi_arvalid;

    always_comb begin
        dpdc_sel_t wsel;
        dpdc_sel_t rsel;
        wsel    = SEL_NONE;
        rsel    = SEL_NONE;
        next_st = st;
        if (aw_take) begin
            next_st.aw_full = 1'b1;
            next_st.aw_idx  = i_s_axi_awaddr[ADDR_W-1:2];
        end
        if (w_take) begin
            next_st.w_full  = 1'b1;
            next_st.w_data  = i_s_axi_wdata[7:0];
            next_st.w_lane0 = i_s_axi_wstrb[0];
        end
        if (st.bvalid && i_s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        // commit once both halves of a write are held
        if (st.aw_full && st.w_full && !st.bvalid) begin
            wsel           = decode_idx(st.aw_idx);
            next_st.aw_full = 1'b0;
            next_st.w_full  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = (wsel == SEL_NONE) ? dpdc_pkg::RESP_SLVERR : dpdc_pkg::RESP_OKAY;
            if (wsel == SEL_MAIN) begin
                next_st.main_cfg = cfg_merge(st.main_cfg, st.w_data, st.w_lane0);
            end
            if (wsel == SEL_AUX) begin
                next_st.aux_cfg = cfg_merge(st.aux_cfg, st.w_data, st.w_lane0);
            end
        end
        if (st.rvalid && i_s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (ar_take) begin
            rsel           = decode_idx(i_s_axi_araddr[ADDR_W-1:2]);
            next_st.rvalid = 1'b1;
            next_st.rresp  = (rsel == SEL_NONE) ? dpdc_pkg::RESP_SLVERR : dpdc_pkg::RESP_OKAY;
            // status is read-only; writes to it answer okay and change nothing
            unique case (rsel)
                SEL_MAIN:   next_st.rdata = st.main_cfg;
                SEL_AUX:    next_st.rdata = st.aux_cfg;
                SEL_STATUS: next_st.rdata = {st.aux_unused, st.aux_factor, st.main_unused, st.main_factor};
                SEL_NONE:   next_st.rdata = 8'h00;
            endcase
        end
        // factors settle one cycle after a code or bandwidth change
        next_st.main_factor = main_dmp.factor;
        next_st.main_unused = main_dmp.code_unused;
        next_st.aux_factor  = aux_dmp.factor;
        next_st.aux_unused  = aux_dmp.code_unused;
        next_st.det_gain    = st.main_cfg[dpdc_pkg::GAIN_LSB +: 3];
        // gain is handed on only under automatic gain selection
        next_st.det_apply   = i_auto_detector_gain_enable & i_main_low_rate_analog;
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= RST_ST;
        end else if (i_clk_en) begin
            st <= next_st;
        end
    end

    assign o_s_axi_bvalid                  = st.bvalid;
    assign o_s_axi_bresp                   = st.bresp;
    assign o_s_axi_rvalid                  = st.rvalid;
    assign o_s_axi_rresp                   = st.rresp;
    assign o_s_axi_rdata                   = {24'h000000, st.rdata};
    assign o_main_damping_select           = st.main_cfg[dpdc_pkg::DAMP_LSB +: 3];
    assign o_main_damping_factor           = st.main_factor;
    assign o_main_code_unused              = st.main_unused;
    assign o_aux_damping_select            = st.aux_cfg[dpdc_pkg::DAMP_LSB +: 3];
    assign o_aux_damping_factor            = st.aux_factor;
    assign o_aux_code_unused               = st.aux_unused;
    assign o_low_rate_analog_detector_gain = st.det_gain;
    assign o_detector_gain_apply           = st.det_apply;
endmodule

// ==== dpdc_config_monitor.sv ====
`timescale 1ns/1ps
module dpdc_config_monitor (
    input wire logic        i_clk_sys,
    input wire logic        i_sys_rst,
    input wire logic        i_clk_en,
    input wire logic        o_s_axi_bvalid,
    input wire logic        i_s_axi_bready,
    input wire logic        o_s_axi_arready,
    input wire logic        o_s_axi_rvalid,
    input wire logic        i_s_axi_rready,
    input wire logic [31:0] o_s_axi_rdata,
    input wire logic [2:0]  i_main_bandwidth,
    input wire logic [2:0]  i_aux_bandwidth,
    input wire logic        i_auto_detector_gain_enable,
    input wire logic        i_main_low_rate_analog,
    input wire logic [2:0]  o_main_damping_select,
    input wire logic [2:0]  o_main_damping_factor,
    input wire logic [2:0]  o_aux_damping_select,
    input wire logic [2:0]  o_aux_damping_factor,
    input wire logic        o_detector_gain_apply
);
    // previous edge was enabled and out of reset
    logic prev_run;
    always_ff @(posedge i_clk_sys) begin
        prev_run <= i_clk_en & ~i_sys_rst;
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    a_bvalid_holds: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
        else $error("write response withdrawn early");
    a_rvalid_holds: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
        else $error("read data withdrawn early");
    a_rdata_upper_zero: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_ar_refused: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
        else $error("read address taken while read pending");
    a_apply_follows: assert property (prev_run |-> o_detector_gain_apply ==
        $past(i_auto_detector_gain_enable & i_main_low_rate_analog)) else $error("gain apply wrong");
    a_code3_five: assert property (prev_run && $past(o_main_damping_select) == 3'h3
        |-> o_main_damping_factor == dpdc_pkg::DF_5) else $error("code 011 factor wrong");
    a_code1_slow: assert property (prev_run && $past(o_main_damping_select) == 3'h1
        && $past(i_main_bandwidth) == 3'h0 |-> o_main_damping_factor == dpdc_pkg::DF_5) else $error("code 001 factor wrong");
    a_code5_fast: assert property (prev_run && $past(o_main_damping_select) == 3'h5
        && $past(i_main_bandwidth) >= 3'h4 |-> o_main_damping_factor == dpdc_pkg::DF_20) else $error("code 101 factor wrong");
    a_aux_code4: assert property (prev_run && $past(o_aux_damping_select) == 3'h4
        && $past(i_aux_bandwidth) == 3'h3 |-> o_aux_damping_factor == dpdc_pkg::DF_10) else $error("aux factor wrong");
endmodule

bind dpdc_config dpdc_config_monitor dpdc_config_monitor_inst (.i_clk_sys, .i_sys_rst, .i_clk_en, .o_s_axi_bvalid,
    .i_s_axi_bready, .o_s_axi_arready, .o_s_axi_rvalid, .i_s_axi_rready, .o_s_axi_rdata, .i_main_bandwidth,
    .i_aux_bandwidth, .i_auto_detector_gain_enable, .i_main_low_rate_analog, .o_main_damping_select,
    .o_main_damping_factor, .o_aux_damping_select, .o_aux_damping_factor, .o_detector_gain_apply);

// ==== dpdc_config_tb.sv ====
`timescale 1ns/1ps
module dpdc_config_tb;
    localparam logic [11:0] A_MAIN = {2'h0, dpdc_pkg::MAIN_CFG_IDX, 2'h0};
    localparam logic [11:0] A_AUX  = {2'h0, dpdc_pkg::AUX_CFG_IDX, 2'h0};
    logic        i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_clk_en = 1'b1;
    logic [11:0] i_s_axi_awaddr = 12'h000, i_s_axi_araddr = 12'h000;
    logic [2:0]  i_s_axi_awprot = 3'h0, i_s_axi_arprot = 3'h0, i_main_bandwidth = 3'h0, i_aux_bandwidth = 3'h2;
    logic        i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_arvalid = 1'b0;
    logic        i_s_axi_bready = 1'b1, i_s_axi_rready = 1'b1;
    logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata, rd;
    logic [3:0]  i_s_axi_wstrb = 4'hF;
    logic        i_auto_detector_gain_enable = 1'b0, i_main_low_rate_analog = 1'b0;
    logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, resp;
    logic [2:0]  o_main_damping_select, o_main_damping_factor, o_aux_damping_select, o_aux_damping_factor;
    logic [2:0]  o_low_rate_analog_detector_gain;
    logic        o_main_code_unused, o_aux_code_unused, o_detector_gain_apply;
    int          failures = 0, samples_checked = 0;
    always #25 i_clk_sys = ~i_clk_sys;
    dpdc_config #(.ADDR_W(12)) dpdc_config_inst (.i_clk_sys, .i_sys_rst, .i_clk_en, .i_s_axi_awaddr, .i_s_axi_awprot,
        .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready,
        .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arprot, .i_s_axi_arvalid,
        .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_main_bandwidth,
        .i_aux_bandwidth, .i_auto_detector_gain_enable, .i_main_low_rate_analog, .o_main_damping_select,
        .o_main_damping_factor, .o_main_code_unused, .o_aux_damping_select, .o_aux_damping_factor,
        .o_aux_code_unused, .o_low_rate_analog_detector_gain, .o_detector_gain_apply);
    task automatic test_done;
        if (failures == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            failures++;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int   n;
        logic aw_ok, w_ok;
        n = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        i_s_axi_awaddr  <= a;
        i_s_axi_wdata   <= d;
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_wvalid  <= 1'b1;
        while (!(aw_ok && w_ok) && n < 100) begin
            @(posedge i_clk_sys);
            n++;
            if (!aw_ok && o_s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                i_s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && o_s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                i_s_axi_wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_s_axi_bvalid !== 1'b1 && n < 100);
        resp = o_s_axi_bresp;
        if (n >= 100) begin
            $display("ERROR t=%0t wait=%h limit=%h", $time, n, 100);
            failures++;
        end
    endtask
    task automatic rdr(input logic [11:0] a);
        int n;
        n = 0;
        i_s_axi_araddr  <= a;
        i_s_axi_arvalid <= 1'b1;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_s_axi_arready !== 1'b1 && n < 100);
        i_s_axi_arvalid <= 1'b0;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_s_axi_rvalid !== 1'b1 && n < 100);
        rd = o_s_axi_rdata;
        resp = o_s_axi_rresp;
        if (n >= 100) begin
            $display("ERROR t=%0t wait=%h limit=%h", $time, n, 100);
            failures++;
        end
    endtask
    function automatic logic [2:0] exp_df(input logic [2:0] c, input logic [2:0] b);
        logic [2:0] w;
        w = (b > 3'h4) ? 3'h4 : b;
        case (c)
            3'h1: exp_df = (w == 3'h0) ? dpdc_pkg::DF_5 : (w == 3'h1) ? dpdc_pkg::DF_2P5 : dpdc_pkg::DF_1P2;
            3'h2: exp_df = (w <= 3'h1) ? dpdc_pkg::DF_5 : dpdc_pkg::DF_2P5;
            3'h4: exp_df = (w <= 3'h2) ? dpdc_pkg::DF_5 : dpdc_pkg::DF_10;
            3'h5: exp_df = (w <= 3'h2) ? dpdc_pkg::DF_5 : (w == 3'h3) ? dpdc_pkg::DF_10 : dpdc_pkg::DF_20;
            default: exp_df = dpdc_pkg::DF_5;
        endcase
    endfunction
    task automatic t_reset;
        chk(32'(o_main_damping_select), 32'h3);
        chk(32'(o_main_damping_factor), 32'(dpdc_pkg::DF_5));
        chk(32'(o_low_rate_analog_detector_gain), 32'h1);
        rdr(A_MAIN);
        chk(rd, 32'h13);
        rdr(A_AUX);
        chk(rd, 32'h13);
    endtask
    task automatic t_table;
        for (int c = 1; c <= 5; c++) begin
            wr(A_MAIN, 32'(c));
            wr(A_AUX, 32'(c));
            chk(32'(o_main_damping_select), 32'(c));
            chk(32'(o_aux_damping_select), 32'(c));
            for (int b = 0; b <= 5; b++) begin
                i_main_bandwidth <= 3'(b);
                i_aux_bandwidth  <= 3'(b);
                repeat (2) @(posedge i_clk_sys);
                chk(32'(o_main_damping_factor), 32'(exp_df(3'(c), 3'(b))));
                if (b >= 2) chk(32'(o_aux_damping_factor), 32'(exp_df(3'(c), 3'(b))));
                chk(32'({o_main_code_unused, o_aux_code_unused}), 32'h0);
            end
        end
    endtask
    task automatic t_fields;
        wr(A_MAIN, 32'hFFFFFFFF);
        rdr(A_MAIN);
        chk(rd, 32'h77);
        chk(32'(o_low_rate_analog_detector_gain), 32'h7);
        i_s_axi_wstrb <= 4'h0;
        wr(A_MAIN, 32'h13);
        i_s_axi_wstrb <= 4'hF;
        rdr(A_MAIN);
        chk(rd, 32'h77);
        wr(A_MAIN, 32'h00);
        repeat (2) @(posedge i_clk_sys);
        chk(32'(o_main_code_unused), 32'h1);
        wr(A_MAIN, 32'h13);
    endtask
    task automatic t_apply;
        for (int k = 0; k < 4; k++) begin
            i_auto_detector_gain_enable <= k[0];
            i_main_low_rate_analog      <= k[1];
            repeat (2) @(posedge i_clk_sys);
            chk(32'(o_detector_gain_apply), 32'(k == 3));
        end
    endtask
    task automatic t_bus;
        wr(12'h100, 32'h5);
        chk(32'(resp), 32'(dpdc_pkg::RESP_SLVERR));
        rdr(12'h100);
        chk(32'(resp), 32'(dpdc_pkg::RESP_SLVERR));
        chk(rd, 32'h0);
        i_clk_en <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        chk(32'(o_s_axi_arready), 32'h0);
        chk(32'({o_s_axi_awready, o_s_axi_wready}), 32'h0);
        i_clk_en <= 1'b1;
        @(posedge i_clk_sys);
        i_s_axi_bready <= 1'b0;
        wr(A_AUX, 32'h13);
        repeat (2) @(posedge i_clk_sys);
        chk(32'(o_s_axi_bvalid), 32'h1);
        i_s_axi_bready <= 1'b1;
        @(posedge i_clk_sys);
        i_s_axi_rready <= 1'b0;
        rdr(A_AUX);
        repeat (2) @(posedge i_clk_sys);
        chk(32'(o_s_axi_rvalid), 32'h1);
        chk(o_s_axi_rdata, 32'h13);
        i_s_axi_rready <= 1'b1;
        @(posedge i_clk_sys);
    endtask
    initial begin
        repeat (10) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        @(posedge i_clk_sys);
        t_reset();
        t_table();
        t_fields();
        t_apply();
        t_bus();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        failures++;
        test_done();
    end
endmodule
